// ### spdp_regs.sv
// control and status registers of the single-pin debug port, on the link clock
// assumes the link layer drives access strobes and events on i_core_clk; system
// status inputs come from another domain and are synchronised here
`timescale 1ns/100ps
`include "spdp_cfg.svh"
module spdp_regs #(
  parameter int unsigned TIMEOUT_CYCLES = `SPDP_TIMEOUT_CYCLES
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [3:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_err_valid,
  input  wire logic [2:0]           i_err_code,
  input  wire logic                 i_parity_err,
  input  wire logic                 i_contention,
  input  wire logic                 i_acc_wait,
  input  wire logic                 i_acc_done,
  input  wire logic                 i_turnaround,
  input  wire logic                 i_nack_req,
  input  wire logic [2:0]           i_key_ok,
  input  wire spdp_pkg::spdp_sys_s  i_sys_async,
  output logic [7:0]                o_reg_rdata,
  output logic                      o_reg_rvalid,
  output spdp_pkg::spdp_ctrl_a_s    o_ctrl_a,
  output spdp_pkg::spdp_ctrl_b_s    o_ctrl_b,
  output logic [1:0]                o_gap_bits,
  output logic                      o_guard_busy,
  output logic                      o_nack_send,
  output logic                      o_sys_reset,
  output logic                      o_sys_clk_req,
  output logic [1:0]                o_link_clock_sel,
  output logic                      o_user_row_done,
  output logic                      o_port_reset
);

  // no processor-side port exists: only the link layer strobes reach this space (see R01)

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    hit = (addr == off);
  endfunction

  spdp_pkg::spdp_sys_s   sys_meta_reg;
  spdp_pkg::spdp_sys_s   sys_reg;
  logic                  prog_go_d_reg;

  spdp_pkg::spdp_ctrl_a_s ctrl_a_reg,   ctrl_a_next;
  spdp_pkg::spdp_ctrl_b_s ctrl_b_reg,   ctrl_b_next;
  logic [2:0]            err_reg,       err_next;
  logic [2:0]            key_reg,       key_next;
  logic [7:0]            rst_req_reg,   rst_req_next;
  logic [1:0]            clk_sel_reg,   clk_sel_next;
  logic                  clk_req_reg,   clk_req_next;
  logic                  urow_done_reg, urow_done_next;
  logic                  sys_rst_reg,   sys_rst_next;
  logic                  done_pls_reg,  done_pls_next;
  logic                  port_rst_reg,  port_rst_next;
  logic                  nack_reg,      nack_next;
  logic [7:0]            rdata_reg,     rdata_next;
  logic                  rvalid_reg,    rvalid_next;
  logic [16:0]           to_cnt_reg,    to_cnt_next;
  spdp_pkg::spdp_guard_e guard_st_reg,  guard_st_next;
  logic [7:0]            guard_cnt_reg, guard_cnt_next;

  logic                  wr_disable;
  logic                  timeout_hit;
  logic                  err_evt;
  logic [2:0]            err_evt_code;

  // two-stage capture of system-domain status
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sys_meta_reg  <= '0;
      sys_reg       <= '0;
      prog_go_d_reg <= 1'b0;
    end else begin
      sys_meta_reg  <= i_sys_async;
      sys_reg       <= sys_meta_reg;
      prog_go_d_reg <= sys_reg.mem_prog_go;
    end
  end

  assign wr_disable  = i_reg_wr && hit(i_reg_addr, `SPDP_OFF_CTRL_B)
                       && i_reg_wdata[`SPDP_BIT_DISABLE];
  assign timeout_hit = (to_cnt_reg == 17'(TIMEOUT_CYCLES - 1)) && i_acc_wait
                       && !ctrl_a_reg.timeout_check_off;

  // error sources in fixed priority; masked checks never raise a code
  always_comb begin
    err_evt      = 1'b1;
    err_evt_code = `SPDP_ERR_NONE;
    if (timeout_hit) begin
      err_evt_code = `SPDP_ERR_TIMEOUT;                           // see R08
    end else if (i_contention && !ctrl_b_reg.contention_check_off) begin
      err_evt_code = `SPDP_ERR_CONTEND;                           // see R13
    end else if (i_parity_err && !ctrl_a_reg.parity_check_off) begin
      err_evt_code = `SPDP_ERR_PARITY;                            // see R06
    end else if (i_err_valid) begin
      err_evt_code = i_err_code;                                  // see R04
    end else begin
      err_evt      = 1'b0;
    end
  end

  // register file next state
  always_comb begin
    ctrl_a_next    = ctrl_a_reg;
    ctrl_b_next    = ctrl_b_reg;
    err_next       = err_reg;
    key_next       = key_reg;
    rst_req_next   = rst_req_reg;
    clk_sel_next   = clk_sel_reg;
    clk_req_next   = clk_req_reg;
    urow_done_next = urow_done_reg;
    done_pls_next  = 1'b0;
    port_rst_next  = 1'b0;
    rvalid_next    = i_reg_rd;
    rdata_next     = 8'h00;
    nack_next      = i_nack_req && !ctrl_b_reg.neg_ack_off && !ctrl_a_reg.response_sig_off; // see R12 R09
    if (i_reg_rd) begin
      case (i_reg_addr)                                           // see R23
        `SPDP_OFF_STATUS_A: rdata_next = {`SPDP_REVISION, 4'h0};  // see R02
        `SPDP_OFF_ERR_SIG:  rdata_next = {5'h00, err_reg};
        `SPDP_OFF_CTRL_A:   rdata_next = {ctrl_a_reg.inter_byte_gap_en, 1'b0,
                                          ctrl_a_reg.parity_check_off,
                                          ctrl_a_reg.timeout_check_off,
                                          ctrl_a_reg.response_sig_off,
                                          ctrl_a_reg.guard_time_sel};
        `SPDP_OFF_CTRL_B:   rdata_next = {3'h0, ctrl_b_reg, 3'h0};
        `SPDP_OFF_KEY_STAT: rdata_next = {2'h0, key_reg, 3'h0};
        `SPDP_OFF_RST_REQ:  rdata_next = rst_req_reg;
        `SPDP_OFF_CLK_SEL:  rdata_next = {6'h00, clk_sel_reg};
        `SPDP_OFF_SYS_CTRL: rdata_next = {6'h00, urow_done_reg, clk_req_reg};
        `SPDP_OFF_SYS_STAT: rdata_next = {2'h0,
                                          sys_reg.system_in_reset | sys_rst_reg,
                                          sys_reg.system_asleep,
                                          sys_reg.mem_prog_go,
                                          sys_reg.user_row_prog_go, 1'b0,
                                          sys_reg.memory_locked};
        `SPDP_OFF_CRC_STAT: rdata_next = {5'h00, sys_reg.crc_state};
        default:            rdata_next = 8'h00;
      endcase
      if (hit(i_reg_addr, `SPDP_OFF_ERR_SIG)) begin
        err_next = `SPDP_ERR_NONE;                                // see R03
      end
    end
    if (i_reg_wr) begin
      case (i_reg_addr)
        `SPDP_OFF_CTRL_A: begin
          ctrl_a_next.inter_byte_gap_en = i_reg_wdata[7];
          ctrl_a_next.parity_check_off  = i_reg_wdata[5];
          ctrl_a_next.timeout_check_off = i_reg_wdata[4];
          ctrl_a_next.response_sig_off  = i_reg_wdata[3];
          ctrl_a_next.guard_time_sel    = i_reg_wdata[2:0];
        end
        `SPDP_OFF_CTRL_B: begin
          ctrl_b_next = spdp_pkg::spdp_ctrl_b_s'(i_reg_wdata[4:3]);  // see R13
        end
        `SPDP_OFF_KEY_STAT: begin
          if (i_reg_wdata[`SPDP_BIT_UROW_KEY]) begin
            key_next[2]    = 1'b0;                                // see R16
            urow_done_next = 1'b0;
          end
        end
        `SPDP_OFF_RST_REQ: begin
          rst_req_next = i_reg_wdata;                             // see R19
        end
        `SPDP_OFF_CLK_SEL: begin
          if (i_reg_wdata[1:0] != 2'h0) begin
            clk_sel_next = i_reg_wdata[1:0];                      // see R21
          end
        end
        `SPDP_OFF_SYS_CTRL: begin
          clk_req_next = i_reg_wdata[`SPDP_BIT_CLK_REQ];          // see R22
          if (key_reg[2]) begin
            urow_done_next = i_reg_wdata[`SPDP_BIT_UROW_DONE];
            done_pls_next  = i_reg_wdata[`SPDP_BIT_UROW_DONE];
          end
        end
        default: begin
        end
      endcase
    end
    sys_rst_next = (rst_req_next == `SPDP_RESET_CODE);            // see R19
    if (sys_rst_next && !sys_rst_reg) begin
      key_next[0] = 1'b0;                                         // see R18
    end
    if (sys_reg.mem_prog_go && !prog_go_d_reg) begin
      key_next[1] = 1'b0;                                         // see R17
    end
    key_next = key_next | i_key_ok;                               // see R15
    if (err_evt) begin
      err_next = err_evt_code;                                    // see R03
    end
    if (wr_disable) begin
      ctrl_a_next    = '0;                                        // see R14
      ctrl_b_next    = '0;
      key_next       = 3'h0;
      rst_req_next   = 8'h00;
      sys_rst_next   = 1'b0;
      clk_sel_next   = `SPDP_CLK_SEL_RST;
      clk_req_next   = 1'b0;
      urow_done_next = 1'b0;
      err_next       = `SPDP_ERR_NONE;
      port_rst_next  = 1'b1;
    end
  end

  // the system reset request resets none of these flops; it only clears the erase key bit key_reg[0] (see R20)
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_a_reg    <= '0;
      ctrl_b_reg    <= '0;
      err_reg       <= `SPDP_ERR_NONE;
      key_reg       <= 3'h0;
      rst_req_reg   <= 8'h00;
      clk_sel_reg   <= `SPDP_CLK_SEL_RST;
      clk_req_reg   <= `SPDP_CLK_REQ_RST;
      urow_done_reg <= 1'b0;
      sys_rst_reg   <= 1'b0;
      done_pls_reg  <= 1'b0;
      port_rst_reg  <= 1'b0;
      nack_reg      <= 1'b0;
      rdata_reg     <= 8'h00;
      rvalid_reg    <= 1'b0;
    end else begin
      ctrl_a_reg    <= ctrl_a_next;
      ctrl_b_reg    <= ctrl_b_next;
      err_reg       <= err_next;
      key_reg       <= key_next;
      rst_req_reg   <= rst_req_next;
      clk_sel_reg   <= clk_sel_next;
      clk_req_reg   <= clk_req_next;
      urow_done_reg <= urow_done_next;
      sys_rst_reg   <= sys_rst_next;
      done_pls_reg  <= done_pls_next;
      port_rst_reg  <= port_rst_next;
      nack_reg      <= nack_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  // access layer time-out and receive-to-transmit guard timer
  always_comb begin
    to_cnt_next    = 17'h00000;
    guard_st_next  = guard_st_reg;
    guard_cnt_next = guard_cnt_reg;
    if (i_acc_wait && !i_acc_done && !timeout_hit && !ctrl_a_reg.timeout_check_off) begin
      to_cnt_next = to_cnt_reg + 17'h00001;                       // see R08
    end
    case (guard_st_reg)
      spdp_pkg::SPDP_GUARD_IDLE: begin
        if (i_turnaround) begin
          guard_st_next  = spdp_pkg::SPDP_GUARD_RUN;
          guard_cnt_next = (ctrl_a_reg.guard_time_sel == 3'h7) ? `SPDP_GUARD_MAX
                           : (`SPDP_GUARD_MAX >> ctrl_a_reg.guard_time_sel);  // see R11
        end
      end
      spdp_pkg::SPDP_GUARD_RUN: begin
        guard_cnt_next = guard_cnt_reg - 8'h01;
        if (guard_cnt_reg == 8'h01) begin
          guard_st_next = spdp_pkg::SPDP_GUARD_IDLE;
        end
      end
      default: begin
        guard_st_next = spdp_pkg::SPDP_GUARD_IDLE;
      end
    endcase
    if (wr_disable) begin
      guard_st_next  = spdp_pkg::SPDP_GUARD_IDLE;
      guard_cnt_next = 8'h00;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      to_cnt_reg    <= 17'h00000;
      guard_st_reg  <= spdp_pkg::SPDP_GUARD_IDLE;
      guard_cnt_reg <= 8'h00;
    end else begin
      to_cnt_reg    <= to_cnt_next;
      guard_st_reg  <= guard_st_next;
      guard_cnt_reg <= guard_cnt_next;
    end
  end

  assign o_reg_rdata      = rdata_reg;
  assign o_reg_rvalid     = rvalid_reg;
  assign o_ctrl_a         = ctrl_a_reg;
  assign o_ctrl_b         = ctrl_b_reg;
  assign o_gap_bits       = ctrl_a_reg.inter_byte_gap_en ? `SPDP_GAP_BITS : 2'h0;  // see R05
  assign o_guard_busy     = (guard_st_reg == spdp_pkg::SPDP_GUARD_RUN);
  assign o_nack_send      = nack_reg;
  assign o_sys_reset      = sys_rst_reg;
  assign o_sys_clk_req    = clk_req_reg;
  assign o_link_clock_sel = clk_sel_reg;
  assign o_user_row_done  = done_pls_reg;
  assign o_port_reset     = port_rst_reg;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_reset_code: assert property (                                 // see R19
    i_reg_wr && hit(i_reg_addr, `SPDP_OFF_RST_REQ) && !wr_disable
    |=> o_sys_reset == ($past(i_reg_wdata) == `SPDP_RESET_CODE))
    else $error("system reset does not follow request code");
  a_err_clear_read: assert property (                             // see R03
    i_reg_rd && hit(i_reg_addr, `SPDP_OFF_ERR_SIG) && !err_evt && !wr_disable
    |=> err_reg == `SPDP_ERR_NONE)
    else $error("error code not cleared by read");
  a_err_read_value: assert property (                             // see R03
    i_reg_rd && hit(i_reg_addr, `SPDP_OFF_ERR_SIG)
    |=> o_reg_rvalid && o_reg_rdata == {5'h00, $past(err_reg)})
    else $error("error code read back wrong");
  a_parity_mask: assert property (                                // see R06
    ctrl_a_reg.parity_check_off && !i_contention && !i_err_valid && !timeout_hit
    && !(i_reg_rd && hit(i_reg_addr, `SPDP_OFF_ERR_SIG)) && !wr_disable
    |=> $stable(err_reg))
    else $error("masked parity changed error code");
  a_timeout_flag: assert property (                               // see R08
    timeout_hit && !wr_disable |=> err_reg == `SPDP_ERR_TIMEOUT)
    else $error("time-out not reported");
  a_guard_len: assert property (                                  // see R11
    !o_guard_busy && i_turnaround && ctrl_a_reg.guard_time_sel == 3'h6 && !wr_disable
    |=> o_guard_busy [*2] ##1 !o_guard_busy)
    else $error("shortest guard time wrong");
  a_disable_all: assert property (                                // see R14
    wr_disable |=> o_port_reset && !o_sys_clk_req && key_reg == 3'h0
                   && o_link_clock_sel == `SPDP_CLK_SEL_RST && !o_sys_reset)
    else $error("port disable left state behind");
  a_key_set: assert property (                                    // see R15
    i_key_ok[1] && !wr_disable |=> key_reg[1])
    else $error("decoded key not shown");
  a_erase_key_clr: assert property (                              // see R18
    $rose(o_sys_reset) && !$past(i_key_ok[0]) |-> !key_reg[0])
    else $error("erase key kept across reset request");
  a_rev_read: assert property (                                   // see R02
    i_reg_rd && hit(i_reg_addr, `SPDP_OFF_STATUS_A)
    |=> o_reg_rdata == {`SPDP_REVISION, 4'h0})
    else $error("revision read wrong");

endmodule

// ### spdp_cfg.svh
// offsets, field positions, reset values and timing counts of the debug port registers
// assumes the including file compiles in the same unit as spdp_pkg
//
// What this block does
// R01: registers reachable only by the external debugger, never by the device CPU.
// R02: upper nibble of status A reports the port revision, read only.
// R03: error code loads on link error and clears when the debugger reads it.
// R04: error codes: none, parity, stop, time-out, start, reserved, bus, contention.
// R05: gap enable inserts two idle bits between bytes of multi-byte loads.
// R06: parity off makes the receiver ignore parity and never flag it.
// R07: debugger uses parity off only for testing.
// R08: access layer silent for 65536 link cycles raises time-out unless disabled.
// R09: response signature off suppresses every response signature.
// R10: debugger disables signatures only when bus delays are predictable.
// R11: guard time on receive-to-transmit turn: 128 down to 2 cycles, code 7 reserved; code 7 here gives 128 cycles.
// R12: negative-ack off suppresses the nack sent on system reset during load/store.
// R13: contention off bit disables collision detection; zero enables it.
// R14: port disable drops clock request, resets port, settings and keys.
// R15: key status bits 5, 4, 3 set on decoded user row, programming, erase keys.
// R16: debugger writes the user row key bit last to end the session.
// R17: programming key clears once system status shows programming started.
// R18: erase key clears when the erase sequence's reset request takes effect.
// R19: writing 0x59 holds system reset; any other value releases it.
// R20: system reset from the request register leaves the port untouched.
// R21: link clock select: 1 is 16 MHz, 2 is 8 MHz, 3 is 4 MHz default, 0 reserved.
// R22: system clock request bit keeps the system clock on through sleep.
// R23: reserved bits read zero and ignore writes.
`ifndef SPDP_CFG_SVH
`define SPDP_CFG_SVH

`define SPDP_OFF_STATUS_A  4'h0
`define SPDP_OFF_ERR_SIG   4'h1
`define SPDP_OFF_CTRL_A    4'h2
`define SPDP_OFF_CTRL_B    4'h3
`define SPDP_OFF_KEY_STAT  4'h7
`define SPDP_OFF_RST_REQ   4'h8
`define SPDP_OFF_CLK_SEL   4'h9
`define SPDP_OFF_SYS_CTRL  4'hA
`define SPDP_OFF_SYS_STAT  4'hB
`define SPDP_OFF_CRC_STAT  4'hC

`define SPDP_LINK_CONTROL_A_MASK    8'hBF
`define SPDP_LINK_CONTROL_B_MASK    8'h18
`define SPDP_BIT_DISABLE   2
`define SPDP_BIT_UROW_KEY  5
`define SPDP_BIT_UROW_DONE 1
`define SPDP_BIT_CLK_REQ   0

`define SPDP_ERR_NONE      3'h0
`define SPDP_ERR_PARITY    3'h1
`define SPDP_ERR_FRAME     3'h2
`define SPDP_ERR_TIMEOUT   3'h3
`define SPDP_ERR_START     3'h4
`define SPDP_ERR_BUS       3'h6
`define SPDP_ERR_CONTEND   3'h7

`define SPDP_RESET_CODE    8'h59
`define SPDP_CLK_SEL_RST   2'h3
`define SPDP_CLK_REQ_RST   1'b1
// revision value is arbitrary
`define SPDP_REVISION      4'h2
`define SPDP_GAP_BITS      2'h2
`define SPDP_GUARD_MAX     8'h80
`define SPDP_TIMEOUT_CYCLES 65536

`endif

// ### spdp_pkg.sv
// types shared by the debug port register block
// assumes nothing of its surroundings
package spdp_pkg;

  typedef struct packed {
    logic       inter_byte_gap_en;
    logic       parity_check_off;
    logic       timeout_check_off;
    logic       response_sig_off;
    logic [2:0] guard_time_sel;
  } spdp_ctrl_a_s;

  typedef struct packed {
    logic neg_ack_off;
    logic contention_check_off;
  } spdp_ctrl_b_s;

  typedef struct packed {
    logic [2:0] crc_state;
    logic       memory_locked;
    logic       user_row_prog_go;
    logic       mem_prog_go;
    logic       system_in_reset;
    logic       system_asleep;
  } spdp_sys_s;

  typedef enum logic { SPDP_GUARD_IDLE, SPDP_GUARD_RUN } spdp_guard_e;

endpackage

// ### spdp_sys_model.sv
// system side of the debug port: access layer answers and system status
// assumes requests arrive as one-cycle pulses on the rising edge of i_core_clk
`timescale 1ns/100ps
module spdp_sys_model (
  input  wire logic           i_core_clk,
  input  wire logic           i_rst_n,
  input  wire logic           i_req,
  input  wire logic           i_slow,
  input  wire logic           i_sys_reset,
  output logic                o_acc_wait,
  output logic                o_acc_done,
  output spdp_pkg::spdp_sys_s o_sys
);
  logic [1:0] age;
  logic       in_rst;
  logic       prog_go;
  always_ff @(posedge i_core_clk) begin
    o_acc_done <= 1'b0;
    in_rst     <= i_sys_reset;
    if (!i_rst_n) begin
      o_acc_wait <= 1'b0;
      age        <= 2'h0;
      prog_go    <= 1'b0;
    end else if (i_req) begin
      o_acc_wait <= 1'b1;
      age        <= 2'h0;
    end else if (o_acc_wait && !i_slow) begin
      age <= age + 2'h1;
      if (age == 2'h2) begin
        o_acc_wait <= 1'b0;
        o_acc_done <= 1'b1;
      end
    end
    // programming may start once the system leaves the requested reset
    if (in_rst && !i_sys_reset) begin
      prog_go <= 1'b1;
    end
  end
  assign o_sys = '{crc_state: 3'h2, memory_locked: 1'b1, user_row_prog_go: 1'b0,
                   mem_prog_go: prog_go, system_in_reset: in_rst, system_asleep: 1'b0};
endmodule

// ### single_pin_debug_port_regs_test.sv
// self-checking bench of the debug port registers through the link-side strobes
// assumes spdp_pkg, spdp_regs and spdp_sys_model are compiled ahead of this file
`timescale 1ns/100ps
module single_pin_debug_port_regs_test;
  logic                   i_core_clk;
  logic                   i_rst_n;
  logic                   wr;
  logic                   rd;
  logic [3:0]             addr;
  logic [7:0]             wdata;
  logic [2:0]             ecode;
  logic [8:0]             evt;
  logic                   slow;
  logic                   acc_wait;
  logic                   acc_done;
  logic [7:0]             rdata;
  logic                   rvalid;
  logic [1:0]             gap;
  logic [1:0]             clk_sel;
  logic                   busy;
  logic                   nack;
  logic                   sys_rst;
  logic                   clk_req;
  logic                   row_done;
  logic                   port_rst;
  spdp_pkg::spdp_ctrl_a_s ctrl_a;
  spdp_pkg::spdp_ctrl_b_s ctrl_b;
  spdp_pkg::spdp_sys_s    sys;
  int                     errors;
  int                     checks_done;
  int                     n;
  logic [3:0]             ra [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'hA,
                                      4'hB, 4'hC, 4'hD};
  logic [7:0]             re [12] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h03, 8'h01, 8'h01, 8'h02, 8'h00};
  spdp_regs #(.TIMEOUT_CYCLES(16)) uut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_err_valid(evt[3]), .i_err_code(ecode),
    .i_parity_err(evt[4]), .i_contention(evt[5]), .i_acc_wait(acc_wait),
    .i_acc_done(acc_done), .i_turnaround(evt[7]), .i_nack_req(evt[6]),
    .i_key_ok(evt[2:0]), .i_sys_async(sys), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_ctrl_a(ctrl_a), .o_ctrl_b(ctrl_b), .o_gap_bits(gap), .o_guard_busy(busy),
    .o_nack_send(nack), .o_sys_reset(sys_rst), .o_sys_clk_req(clk_req),
    .o_link_clock_sel(clk_sel), .o_user_row_done(row_done), .o_port_reset(port_rst));
  spdp_sys_model model (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(evt[8]), .i_slow(slow),
    .i_sys_reset(sys_rst), .o_acc_wait(acc_wait), .o_acc_done(acc_done), .o_sys(sys));
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk) begin
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
    end
    @(posedge i_core_clk) wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_core_clk) begin
      rd   <= 1'b1;
      addr <= a;
    end
    @(posedge i_core_clk) rd <= 1'b0;
    #1;
    chk("rvalid", {7'h0, rvalid}, 8'h01);
    chk($sformatf("reg %h", a), rdata, exp);
  endtask
  task automatic ev(input logic [8:0] v, input logic [2:0] c);
    @(posedge i_core_clk) begin
      evt   <= v;
      ecode <= c;
    end
    @(posedge i_core_clk) evt <= 9'h000;
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    complete_run();
  end
  initial begin
    {wr, rd, addr, wdata, ecode, evt, slow, errors, checks_done} = '0;
    i_rst_n = 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1;
    chk("clk_sel", {6'h0, clk_sel}, 8'h03);
    for (int i = 0; i < 12; i++) rreg(ra[i], re[i]);
    wreg(4'h2, 8'hFF);
    rreg(4'h2, 8'hBF);
    chk("ctrl_a", {1'b0, ctrl_a}, 8'h7F);
    wreg(4'h3, 8'hFB);
    rreg(4'h3, 8'h18);
    chk("ctrl_b", {6'h0, ctrl_b}, 8'h03);
    wreg(4'h2, 8'h00);
    wreg(4'h3, 8'h00);
    ev(9'h010, 3'h0);
    rreg(4'h1, 8'h01);
    rreg(4'h1, 8'h00);
    ev(9'h020, 3'h0);
    rreg(4'h1, 8'h07);
    for (int c = 2; c <= 6; c += 2) begin
      ev(9'h008, 3'(c));
      rreg(4'h1, 8'(c));
    end
    wreg(4'h2, 8'h20);
    wreg(4'h3, 8'h08);
    ev(9'h030, 3'h0);
    rreg(4'h1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ev(9'h100, 3'h0);
      repeat (4) @(posedge i_core_clk);
    end
    rreg(4'h1, 8'h00);
    slow <= 1'b1;
    ev(9'h100, 3'h0);
    repeat (24) @(posedge i_core_clk);
    rreg(4'h1, 8'h03);
    wreg(4'h2, 8'h10);
    repeat (40) @(posedge i_core_clk);
    rreg(4'h1, 8'h00);
    slow <= 1'b0;
    for (int s = 0; s < 8; s++) begin
      wreg(4'h2, 8'(s));
      ev(9'h080, 3'h0);
      n = 0;
      while (busy === 1'b1 && n < 300) begin
        @(posedge i_core_clk);
        #1;
        n++;
      end
      chk("guard", n[7:0], (s == 7) ? 8'h80 : (8'h80 >> s));
    end
    wreg(4'h2, 8'h00);
    ev(9'h040, 3'h0);
    chk("nack", {7'h0, nack}, 8'h01);
    wreg(4'h3, 8'h10);
    ev(9'h040, 3'h0);
    chk("nack", {7'h0, nack}, 8'h00);
    wreg(4'h3, 8'h00);
    wreg(4'h2, 8'h08);
    ev(9'h040, 3'h0);
    chk("nack", {7'h0, nack}, 8'h00);
    wreg(4'h2, 8'h81);
    chk("gap", {6'h0, gap}, 8'h02);
    ev(9'h007, 3'h0);
    rreg(4'h7, 8'h38);
    wreg(4'h8, 8'h59);
    chk("sys_rst", {7'h0, sys_rst}, 8'h01);
    rreg(4'h7, 8'h30);
    rreg(4'hB, 8'h21);
    wreg(4'h8, 8'h5A);
    chk("sys_rst", {7'h0, sys_rst}, 8'h00);
    repeat (8) @(posedge i_core_clk);
    rreg(4'h7, 8'h20);
    rreg(4'hB, 8'h09);
    rreg(4'h2, 8'h81);
    wreg(4'hA, 8'h03);
    chk("row_done", {7'h0, row_done}, 8'h01);
    wreg(4'h7, 8'h20);
    rreg(4'h7, 8'h00);
    wreg(4'hA, 8'h02);
    chk("row_done", {7'h0, row_done}, 8'h00);
    chk("clk_req", {7'h0, clk_req}, 8'h00);
    wreg(4'hA, 8'h01);
    chk("clk_req", {7'h0, clk_req}, 8'h01);
    for (int k = 1; k < 3; k++) begin
      wreg(4'h9, 8'(k));
      rreg(4'h9, 8'(k));
    end
    wreg(4'h9, 8'h00);
    rreg(4'h9, 8'h02);
    ev(9'h007, 3'h0);
    wreg(4'h3, 8'h04);
    chk("port_rst", {7'h0, port_rst}, 8'h01);
    chk("clk_req", {7'h0, clk_req}, 8'h00);
    rreg(4'h2, 8'h00);
    rreg(4'h7, 8'h00);
    rreg(4'h9, 8'h03);
    complete_run();
  end
endmodule
